// [hw/ioevt_pkg.sv]
// Constants for the input event and configuration bank
package ioevt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_IN4_EDGE = 6'h1c;
  localparam logic [5:0] IDX_IN5_EDGE = 6'h1d;
  localparam logic [5:0] IDX_IN6_EDGE = 6'h1e;
  localparam logic [5:0] IDX_IN7_EDGE = 6'h1f;
  localparam logic [5:0] IDX_SETTLE = 6'h20;
  localparam logic [5:0] IDX_AIN0_UP_MSB = 6'h21;
  localparam logic [5:0] IDX_AIN0_UP_LSB = 6'h22;
  localparam logic [5:0] IDX_AIN0_LO_MSB = 6'h23;
  localparam logic [5:0] IDX_AIN0_LO_LSB = 6'h24;
  localparam logic [5:0] IDX_AIN0_PERIOD = 6'h25;
  localparam logic [5:0] IDX_AIN1_UP_MSB = 6'h26;
  localparam logic [5:0] IDX_AIN1_UP_LSB = 6'h27;
  localparam logic [5:0] IDX_AIN1_LO_MSB = 6'h28;
  localparam logic [5:0] IDX_AIN1_LO_LSB = 6'h29;
  localparam logic [5:0] IDX_AIN1_PERIOD = 6'h2a;
  localparam logic [5:0] IDX_CTS_HOLD = 6'h2b;
  localparam logic [5:0] IDX_TRACKING = 6'h2c;
  localparam logic [5:0] IDX_SERIAL_ID0 = 6'h2d;
  localparam logic [5:0] IDX_SERIAL_ID3 = 6'h30;
  localparam logic [5:0] IDX_NET_GROUP0 = 6'h31;
  localparam logic [5:0] IDX_NET_GROUP3 = 6'h34;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h38;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h39;
  localparam logic [5:0] IDX_CONTROL = 6'h3a;
  localparam logic [5:0] IDX_PIN_STATE = 6'h3b;

  // Values after reset
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_SETTLE = 8'h0a;
  localparam logic [2:0] RST_UP_MSB = 3'h7;
  localparam logic [7:0] RST_UP_LSB = 8'hff;
  localparam logic [2:0] RST_LO_MSB = 3'h0;
  localparam logic [7:0] RST_LO_LSB = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'h64;
  localparam logic [7:0] RST_CTS_HOLD = 8'h06;
  localparam logic [7:0] RST_TRACKING = 8'h00;
  localparam logic [31:0] RST_SERIAL_ID = 32'h00000000;
  localparam logic [31:0] RST_NET_GROUP = 32'h00000001;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [6:0] RST_CONTROL = 7'h0f;

  // Control register fields
  localparam int CTL_GATEWAY = 4;
  localparam int CTL_AIN0_ON = 5;

  // Edge trigger codes
  localparam logic [7:0] TRIG_RISE = 8'h01;
  localparam logic [7:0] TRIG_FALL = 8'h02;
  localparam logic [7:0] TRIG_BOTH = 8'h03;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0] MS_PER_UNIT = 4'ha;
endpackage

// [hw/ioevt_bank.sv]
// Input event logic, analogue level triggers and configuration registers
// Overview of operation
// - Each enabled digital input raises an event by its code: 0 none, 1 rise, 2 fall, 3 both, other codes none.
// - All digital inputs share one settle time of 0 to 255 ms, 10 ms after reset, before a change is accepted.
// - Each analogue input has an 11-bit upper level, upper byte 0 to 7 and lower byte 0 to 255, reset to 7 and 255.
// - Each analogue input has an 11-bit lower level of the same format, both bytes reset to zero.
// - Clear-to-send is held off for a time in 10 ms units, 6 after reset, only in gateway mode.
// - The serial id is four bytes, least significant first, and all zeros is invalid.
// - A clear-to-send hold time of zero acts as one.
// - The network group id is four bytes, least significant first, and all zeros is invalid.
`timescale 1ns/100ps
module ioevt_bank #(
  parameter int MS_CYCLES = ioevt_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Digital inputs 4 to 7 and analogue samples
  input wire logic [3:0] input_pin,
  input wire logic [10:0] ain0_value,
  input wire logic [10:0] ain1_value,
  // Serial flow control
  input wire logic serial_busy,
  output logic clear_to_send,
  // Identity and feature outputs
  output logic tracking_enable,
  output logic [31:0] serial_id,
  output logic serial_id_valid,
  output logic [31:0] network_group,
  output logic network_group_valid,
  // Interrupt
  output logic irq
);
  import ioevt_pkg::*;

  logic [7:0] edge_sel [4];
  logic [7:0] settle_time;
  logic [2:0] up_msb [2];
  logic [7:0] up_lsb [2];
  logic [2:0] lo_msb [2];
  logic [7:0] lo_lsb [2];
  logic [7:0] period [2];
  logic [7:0] cts_hold;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [6:0] control;
  logic [10:0] ain_value [2];
  logic [3:0] stable;
  logic [3:0] dig_event;
  logic [3:0] ana_event;
  logic [31:0] rdata;
  logic rd_unmapped;
  logic [5:0] idx;
  logic setup;
  logic access;
  logic wr;
  logic bad_req;
  logic status_read;
  logic [31:0] ms_count;
  logic ms_tick;
  logic [3:0] unit_count;
  logic unit_tick;
  logic [7:0] cts_count;

  assign ain_value[0] = ain0_value;
  assign ain_value[1] = ain1_value;
  assign idx = paddr[7:2];
  assign setup = psel & penable & ~pready;
  assign access = psel & penable & pready;
  assign wr = access & pwrite & ~pslverr;
  // Unmapped index or misaligned byte address; refused with zero data
  assign bad_req = rd_unmapped | (paddr[1:0] != 2'h0);
  assign status_read = access & ~pwrite & (idx == IDX_IRQ_STATUS);

  // One wait state; data and error are registered with pready
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      // Error stands for the pready cycle only
      pslverr <= setup & bad_req;
      if (setup) begin
        prdata <= (pwrite | bad_req) ? 32'h00000000 : rdata;
      end
    end
  end

  always_comb begin
    rdata = 32'h00000000;
    rd_unmapped = 1'b0;
    case (idx)
      IDX_IN4_EDGE: rdata[7:0] = edge_sel[0];
      IDX_IN5_EDGE: rdata[7:0] = edge_sel[1];
      IDX_IN6_EDGE: rdata[7:0] = edge_sel[2];
      IDX_IN7_EDGE: rdata[7:0] = edge_sel[3];
      IDX_SETTLE: rdata[7:0] = settle_time;
      IDX_AIN0_UP_MSB: rdata[2:0] = up_msb[0];
      IDX_AIN0_UP_LSB: rdata[7:0] = up_lsb[0];
      IDX_AIN0_LO_MSB: rdata[2:0] = lo_msb[0];
      IDX_AIN0_LO_LSB: rdata[7:0] = lo_lsb[0];
      IDX_AIN0_PERIOD: rdata[7:0] = period[0];
      IDX_AIN1_UP_MSB: rdata[2:0] = up_msb[1];
      IDX_AIN1_UP_LSB: rdata[7:0] = up_lsb[1];
      IDX_AIN1_LO_MSB: rdata[2:0] = lo_msb[1];
      IDX_AIN1_LO_LSB: rdata[7:0] = lo_lsb[1];
      IDX_AIN1_PERIOD: rdata[7:0] = period[1];
      IDX_CTS_HOLD: rdata[7:0] = cts_hold;
      IDX_TRACKING: rdata[0] = tracking_enable;
      IDX_SERIAL_ID0: rdata[7:0] = serial_id[7:0];
      IDX_SERIAL_ID0 + 6'h1: rdata[7:0] = serial_id[15:8];
      IDX_SERIAL_ID0 + 6'h2: rdata[7:0] = serial_id[23:16];
      IDX_SERIAL_ID3: rdata[7:0] = serial_id[31:24];
      IDX_NET_GROUP0: rdata[7:0] = network_group[7:0];
      IDX_NET_GROUP0 + 6'h1: rdata[7:0] = network_group[15:8];
      IDX_NET_GROUP0 + 6'h2: rdata[7:0] = network_group[23:16];
      IDX_NET_GROUP3: rdata[7:0] = network_group[31:24];
      IDX_IRQ_STATUS: rdata[7:0] = irq_status;
      IDX_IRQ_MASK: rdata[7:0] = irq_mask;
      IDX_CONTROL: rdata[6:0] = control;
      IDX_PIN_STATE: rdata[6:0] = {cts_count != 8'h00, network_group_valid,
                                   serial_id_valid, stable};
      default: rd_unmapped = 1'b1;
    endcase
  end

  // Configuration writes take effect on the access edge only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        edge_sel[i] <= RST_EDGE;
      end
      for (int i = 0; i < 2; i++) begin
        up_msb[i] <= RST_UP_MSB;
        up_lsb[i] <= RST_UP_LSB;
        lo_msb[i] <= RST_LO_MSB;
        lo_lsb[i] <= RST_LO_LSB;
        period[i] <= RST_PERIOD;
      end
      settle_time <= RST_SETTLE;
      cts_hold <= RST_CTS_HOLD;
      tracking_enable <= RST_TRACKING[0];
      irq_mask <= RST_IRQ_MASK;
      control <= RST_CONTROL;
    end else if (wr) begin
      case (idx)
        IDX_IN4_EDGE: edge_sel[0] <= pwdata[7:0];
        IDX_IN5_EDGE: edge_sel[1] <= pwdata[7:0];
        IDX_IN6_EDGE: edge_sel[2] <= pwdata[7:0];
        IDX_IN7_EDGE: edge_sel[3] <= pwdata[7:0];
        IDX_SETTLE: settle_time <= pwdata[7:0];
        // Upper byte beyond 7 is clipped to 7
        IDX_AIN0_UP_MSB: up_msb[0] <= |pwdata[7:3] ? 3'h7 : pwdata[2:0];
        IDX_AIN0_UP_LSB: up_lsb[0] <= pwdata[7:0];
        IDX_AIN0_LO_MSB: lo_msb[0] <= |pwdata[7:3] ? 3'h7 : pwdata[2:0];
        IDX_AIN0_LO_LSB: lo_lsb[0] <= pwdata[7:0];
        IDX_AIN0_PERIOD: period[0] <= pwdata[7:0];
        IDX_AIN1_UP_MSB: up_msb[1] <= |pwdata[7:3] ? 3'h7 : pwdata[2:0];
        IDX_AIN1_UP_LSB: up_lsb[1] <= pwdata[7:0];
        IDX_AIN1_LO_MSB: lo_msb[1] <= |pwdata[7:3] ? 3'h7 : pwdata[2:0];
        IDX_AIN1_LO_LSB: lo_lsb[1] <= pwdata[7:0];
        IDX_AIN1_PERIOD: period[1] <= pwdata[7:0];
        IDX_CTS_HOLD: cts_hold <= pwdata[7:0];
        IDX_TRACKING: tracking_enable <= pwdata[0];
        IDX_IRQ_MASK: irq_mask <= pwdata[7:0];
        IDX_CONTROL: control <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // Identity bytes, least significant byte at the lowest index;
  // a multi-byte value is only coherent after its last byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_id <= RST_SERIAL_ID;
      network_group <= RST_NET_GROUP;
    end else if (wr) begin
      case (idx)
        IDX_SERIAL_ID0: serial_id[7:0] <= pwdata[7:0];
        IDX_SERIAL_ID0 + 6'h1: serial_id[15:8] <= pwdata[7:0];
        IDX_SERIAL_ID0 + 6'h2: serial_id[23:16] <= pwdata[7:0];
        IDX_SERIAL_ID3: serial_id[31:24] <= pwdata[7:0];
        IDX_NET_GROUP0: network_group[7:0] <= pwdata[7:0];
        IDX_NET_GROUP0 + 6'h1: network_group[15:8] <= pwdata[7:0];
        IDX_NET_GROUP0 + 6'h2: network_group[23:16] <= pwdata[7:0];
        IDX_NET_GROUP3: network_group[31:24] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Validity is registered, so it follows a write by one cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_id_valid <= 1'b0;
      network_group_valid <= 1'b0;
    end else begin
      serial_id_valid <= serial_id != 32'h00000000;
      network_group_valid <= network_group != 32'h00000000;
    end
  end

  // Millisecond and 10 ms time base
  // Ticks are registered, so every user sees the same phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ms_count <= 32'h00000000;
      ms_tick <= 1'b0;
      unit_count <= 4'h0;
      unit_tick <= 1'b0;
    end else begin
      ms_tick <= ms_count == 32'(MS_CYCLES - 1);
      ms_count <= (ms_count == 32'(MS_CYCLES - 1)) ? 32'h00000000
                                                   : ms_count + 32'h1;
      unit_tick <= ms_tick && unit_count == MS_PER_UNIT - 4'h1;
      if (ms_tick) begin
        unit_count <= (unit_count == MS_PER_UNIT - 4'h1) ? 4'h0
                                                         : unit_count + 4'h1;
      end
    end
  end

  // Digital inputs: settle filter and edge events
  for (genvar g = 0; g < 4; g++) begin : g_din
    logic [7:0] settle_count;
    logic accept;
    // A pin that bounces back restarts its count
    assign accept = input_pin[g] != stable[g] && settle_count >= settle_time;
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        stable[g] <= 1'b0;
        settle_count <= 8'h00;
      end else if (input_pin[g] == stable[g]) begin
        settle_count <= 8'h00;
      end else if (accept) begin
        stable[g] <= input_pin[g];
        settle_count <= 8'h00;
      end else if (ms_tick) begin
        settle_count <= settle_count + 8'h01;
      end
    end
    // Codes above 3 match no case and give no event
    always_comb begin
      dig_event[g] = 1'b0;
      if (accept && control[g]) begin
        case (edge_sel[g])
          TRIG_RISE: dig_event[g] = input_pin[g];
          TRIG_FALL: dig_event[g] = ~input_pin[g];
          TRIG_BOTH: dig_event[g] = 1'b1;
          default: dig_event[g] = 1'b0;
        endcase
      end
    end
  end

  // Analogue inputs: periodic sample against both levels
  for (genvar a = 0; a < 2; a++) begin : g_ain
    logic [7:0] tick_count;
    logic [7:0] eff_period;
    logic above;
    logic below;
    logic sample_now;
    logic [10:0] upper;
    logic [10:0] lower;
    assign upper = {up_msb[a], up_lsb[a]};
    assign lower = {lo_msb[a], lo_lsb[a]};
    // A zero period runs as one unit, so it samples every unit
    assign eff_period = (period[a] == 8'h00) ? 8'h01 : period[a];
    assign sample_now = unit_tick && control[CTL_AIN0_ON + a]
                        && tick_count + 8'h01 >= eff_period;
    // The first unit after enabling may be partial
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        tick_count <= 8'h00;
        above <= 1'b0;
        below <= 1'b0;
      end else if (!control[CTL_AIN0_ON + a]) begin
        tick_count <= 8'h00;
        above <= 1'b0;
        below <= 1'b0;
      end else if (sample_now) begin
        tick_count <= 8'h00;
        above <= ain_value[a] > upper;
        below <= ain_value[a] < lower;
      end else if (unit_tick) begin
        tick_count <= tick_count + 8'h01;
      end
    end
    // Events fire on entering a region, not while staying in it
    assign ana_event[2 * a] = sample_now && !above
                              && ain_value[a] > upper;
    assign ana_event[2 * a + 1] = sample_now && !below
                                  && ain_value[a] < lower;
  end

  // Clear-to-send hold after the serial path frees up
  // Hold reloads while busy, so it counts from the end of busy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cts_count <= 8'h00;
      clear_to_send <= 1'b0;
    end else begin
      if (serial_busy) begin
        cts_count <= (cts_hold == 8'h00) ? 8'h01 : cts_hold;
      end else if (unit_tick && cts_count != 8'h00) begin
        cts_count <= cts_count - 8'h01;
      end
      clear_to_send <= !serial_busy && (cts_count == 8'h00
                       || !control[CTL_GATEWAY]);
    end
  end

  // Sticky event status, cleared by a read; a new event wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status <= 8'h00;
      irq <= 1'b0;
    end else begin
      // Clear only the bits the read returned: an event that lands between
      // data capture and the access edge stays pending
      if (status_read) begin
        irq_status <= (irq_status & ~prdata[7:0]) | {ana_event, dig_event};
      end else begin
        irq_status <= irq_status | {ana_event, dig_event};
      end
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule

// [verif/ioevt_bank_props.sv]
// Port-level checks for the input event bank
`timescale 1ns/100ps
module ioevt_bank_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flow control and identity
  input wire logic serial_busy,
  input wire logic clear_to_send,
  input wire logic [31:0] serial_id,
  input wire logic serial_id_valid,
  input wire logic [31:0] network_group,
  input wire logic network_group_valid
);
  logic bad_addr;
  // Holes in the map and misaligned bytes are both refused
  assign bad_addr = paddr[7:2] < 6'h1c || paddr[7:2] > 6'h3b
    || (paddr[7:2] > 6'h34 && paddr[7:2] < 6'h38) || paddr[1:0] != 2'h0;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_refused;
    s_access ##0 bad_addr;
  endsequence
  a_ready_one_wait: assert property (s_access |=> pready)
    else $error("pready missing after first access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_refused_error: assert property (s_refused |=> pslverr && prdata == 32'h0)
    else $error("bad address not refused");
  a_mapped_no_error: assert property (s_access ##0 !bad_addr |=> !pslverr)
    else $error("mapped address refused");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_byte_data: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  a_busy_blocks_cts: assert property (
    serial_busy |=> !clear_to_send)
    else $error("clear_to_send high while busy");
  a_serial_id_valid: assert property (
    !$past(reset) |-> serial_id_valid == ($past(serial_id) != 32'h0))
    else $error("serial id valid flag wrong");
  a_group_valid: assert property (
    !$past(reset) |-> network_group_valid == ($past(network_group) != 32'h0))
    else $error("network group valid flag wrong");
endmodule

// [verif/ioevt_sources.sv]
// Model of the external digital and analogue input sources
`timescale 1ns/100ps
module ioevt_sources (
  // Clock
  input wire logic clk,
  // Levels seen by the bank
  output logic [3:0] input_pin,
  output logic [10:0] ain0_value,
  output logic [10:0] ain1_value
);
  initial begin
    input_pin = 4'h0;
    ain0_value = 11'h020;
    ain1_value = 11'h7ff;
  end
  // Levels move just after an edge, like a synchronised source
  task automatic set_pin(input int n, input logic v);
    @(posedge clk);
    input_pin[n] <= v;
  endtask
  task automatic set_ain0(input logic [10:0] v);
    @(posedge clk);
    ain0_value <= v;
  endtask
endmodule

// [verif/tb.sv]
// Self-checking bench for the input event bank
`timescale 1ns/100ps
module tb;
  import ioevt_pkg::*;
  localparam logic [5:0] RV_IDX [10] = '{IDX_IN4_EDGE, IDX_SETTLE,
    IDX_AIN0_UP_MSB, IDX_AIN0_UP_LSB, IDX_AIN0_LO_MSB, IDX_AIN0_LO_LSB,
    IDX_AIN1_PERIOD, IDX_CTS_HOLD, IDX_TRACKING, IDX_CONTROL};
  localparam logic [7:0] RV_VAL [10] = '{RST_EDGE, RST_SETTLE,
    {5'h0, RST_UP_MSB}, RST_UP_LSB, {5'h0, RST_LO_MSB}, RST_LO_LSB,
    RST_PERIOD, RST_CTS_HOLD, RST_TRACKING, {1'b0, RST_CONTROL}};
  localparam logic [10:0] AIN_V [4] = '{11'h040, 11'h041, 11'h010, 11'h00f};
  localparam logic [7:0] AIN_ST [4] = '{8'h00, 8'h10, 8'h00, 8'h20};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic serial_busy = 1'b0;
  logic [31:0] prdata, serial_id, network_group, rdat;
  logic pready, pslverr, clear_to_send, tracking_enable, rerr;
  logic serial_id_valid, network_group_valid, irq;
  logic [3:0] input_pin;
  logic [10:0] ain0_value, ain1_value;
  int n_errors = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  ioevt_sources ioevt_sources_i (.clk(clk), .input_pin(input_pin),
    .ain0_value(ain0_value), .ain1_value(ain1_value));
  ioevt_bank #(.MS_CYCLES(10)) ioevt_bank_i (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_pin(input_pin), .ain0_value(ain0_value),
    .ain1_value(ain1_value), .serial_busy(serial_busy),
    .clear_to_send(clear_to_send), .tracking_enable(tracking_enable),
    .serial_id(serial_id), .serial_id_valid(serial_id_valid),
    .network_group(network_group),
    .network_group_valid(network_group_valid), .irq(irq));
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic busy_pulse();
    @(posedge clk);
    serial_busy <= 1'b1;
    repeat (3) @(posedge clk);
    serial_busy <= 1'b0;
  endtask
  task automatic t_resets();
    for (int k = 0; k < 10; k++) begin
      apb(1'b0, RV_IDX[k], 8'h00);
      chk(rdat, {24'h0, RV_VAL[k]});
    end
    chk(network_group, RST_NET_GROUP);
    apb(1'b0, IDX_NET_GROUP0, 8'h00);
    chk(rdat, 32'h1);
    chk({network_group_valid, serial_id_valid}, 2'b10);
    apb(1'b0, 6'h36, 8'h00);
    chk({rerr, rdat[7:0]}, 9'h100);
    apb(1'b1, IDX_AIN0_UP_MSB, 8'h0f);
    apb(1'b0, IDX_AIN0_UP_MSB, 8'h00);
    chk(rdat, 32'h7);
    $display("reset values test done");
  endtask
  task automatic t_edges();
    logic er, ef;
    apb(1'b1, IDX_SETTLE, 8'h00);
    apb(1'b1, IDX_IRQ_MASK, 8'hff);
    // Code 4 is out of range and must act as no trigger
    for (int c = 0; c < 5; c++) begin
      er = (c == 1 || c == 3);
      ef = (c == 2 || c == 3);
      apb(1'b1, IDX_IN4_EDGE, c[7:0]);
      ioevt_sources_i.set_pin(0, 1'b1);
      repeat (4) @(posedge clk);
      chk(irq, er);
      apb(1'b0, IDX_IRQ_STATUS, 8'h00);
      chk(rdat, {31'h0, er});
      ioevt_sources_i.set_pin(0, 1'b0);
      repeat (4) @(posedge clk);
      apb(1'b0, IDX_IRQ_STATUS, 8'h00);
      chk(rdat, {31'h0, ef});
    end
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    $display("edge code test done");
  endtask
  task automatic t_settle();
    apb(1'b1, IDX_SETTLE, 8'h02);
    apb(1'b1, IDX_IN5_EDGE, TRIG_BOTH);
    ioevt_sources_i.set_pin(1, 1'b1);
    repeat (7) @(posedge clk);
    ioevt_sources_i.set_pin(1, 1'b0);
    repeat (40) @(posedge clk);
    chk(irq, 1'b0);
    ioevt_sources_i.set_pin(1, 1'b1);
    repeat (8) @(posedge clk);
    chk(irq, 1'b0);
    repeat (30) @(posedge clk);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk(rdat, 32'h2);
    $display("settle test done");
  endtask
  task automatic t_ids();
    for (int k = 0; k < 4; k++)
      apb(1'b1, IDX_SERIAL_ID0 + 6'(k), 8'h12 + 8'h22 * 8'(k));
    for (int k = 0; k < 4; k++)
      apb(1'b1, IDX_NET_GROUP0 + 6'(k), 8'h00);
    repeat (2) @(posedge clk);
    chk(serial_id, 32'h78563412);
    chk({serial_id_valid, network_group_valid}, 2'b10);
    apb(1'b1, IDX_NET_GROUP0, 8'ha5);
    repeat (2) @(posedge clk);
    chk(network_group, 32'h000000a5);
    chk(network_group_valid, 1'b1);
    apb(1'b1, IDX_TRACKING, 8'h01);
    @(posedge clk);
    chk(tracking_enable, 1'b1);
    $display("identifier test done");
  endtask
  task automatic t_cts();
    busy_pulse();
    chk(clear_to_send, 1'b0);
    repeat (3) @(posedge clk);
    chk(clear_to_send, 1'b1);
    apb(1'b1, IDX_CONTROL, 8'h1f);
    apb(1'b1, IDX_CTS_HOLD, 8'h03);
    busy_pulse();
    repeat (190) @(posedge clk);
    chk(clear_to_send, 1'b0);
    repeat (120) @(posedge clk);
    chk(clear_to_send, 1'b1);
    apb(1'b1, IDX_CTS_HOLD, 8'h00);
    busy_pulse();
    repeat (2) @(posedge clk);
    chk(clear_to_send, 1'b0);
    repeat (108) @(posedge clk);
    chk(clear_to_send, 1'b1);
    $display("clear to send test done");
  endtask
  task automatic t_ain();
    apb(1'b1, IDX_AIN0_UP_MSB, 8'h00);
    apb(1'b1, IDX_AIN0_UP_LSB, 8'h40);
    apb(1'b1, IDX_AIN0_LO_LSB, 8'h10);
    apb(1'b1, IDX_AIN0_PERIOD, 8'h01);
    apb(1'b1, IDX_CONTROL, 8'h2f);
    // Levels are strict: equal to a level raises nothing
    for (int k = 0; k < 4; k++) begin
      ioevt_sources_i.set_ain0(AIN_V[k]);
      repeat (250) @(posedge clk);
      apb(1'b0, IDX_IRQ_STATUS, 8'h00);
      chk(rdat, {24'h0, AIN_ST[k]});
    end
    // Second input sits at full scale, just above a lowered upper level
    apb(1'b1, IDX_AIN1_UP_LSB, 8'hfe);
    apb(1'b1, IDX_AIN1_PERIOD, 8'h01);
    apb(1'b1, IDX_CONTROL, 8'h4f);
    repeat (250) @(posedge clk);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk(rdat, 32'h40);
    $display("analogue test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_resets();
    t_edges();
    t_settle();
    t_ids();
    t_cts();
    t_ain();
    close_out();
  end
endmodule
bind ioevt_bank ioevt_bank_props ioevt_bank_props_i (.clk(clk),
  .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_busy(serial_busy), .clear_to_send(clear_to_send),
  .serial_id(serial_id), .serial_id_valid(serial_id_valid),
  .network_group(network_group),
  .network_group_valid(network_group_valid));
